// ---- hdl/mfp_pkg.sv ----
// Purpose: constants for the multifunction pin function-code decoder
// Assumes: codes 0x23..0x3B only; other code ranges decode to nothing
// Notes: status register fields arrive as plain byte-wide ports
//
// Summary of operation
// R1: each pin holds a 7-bit code: control when input, status when output.
// R2: input code 0x23 forces the fault control of ref_in_3.
// R3: output code 0x23 drives the ref_in_3 faulted flag.
// R4: output codes 0x24..0x27 drive the valid flags of ref_in_0..3.
// R5: input codes 0x28..0x2B validate the matching reference only if it is faulted.
// R6: output codes 0x28..0x2B show reference active, a combination of several bits.
// R7: output codes 0x30..0x32 drive digital_loop_0 phase/freq lock and analog_loop_0 lock.
// R8: output code 0x33 drives analog_loop_0 calibration in progress.
// R9: output code 0x34 drives digital_loop_0 active, OR of six status bits.
// R10: output codes 0x35..0x37 drive digital_loop_0 freerun, holdover, switching.
// R11: output codes 0x38, 0x3A, 0x3B drive tuning history, clamped, slew limited.
// R12: output code 0x39 drives the tuning-history-updated event flag.
// R13: unassigned or not-applicable input codes touch no control bit.
// R14: output codes 0x2E/0x2F show feedback 0/1 active; 0x2C/0x2D stay low.
package mfp_pkg;
  localparam int CODE_W = 7;
  localparam int NUM_REFS = 4;
  localparam int STAT_W = 25;
  localparam logic [6:0] CODE_FIRST = 7'h23;
  localparam logic [6:0] CODE_LAST = 7'h3B;
  localparam logic [6:0] CODE_FAULT_REF3 = 7'h23;
  localparam logic [6:0] CODE_VALID_REF0 = 7'h24;
  localparam logic [6:0] CODE_TIMEOUT_REF0 = 7'h28;
  localparam logic [6:0] CODE_ACTIVE_REF0 = 7'h28;
  localparam logic [6:0] CODE_FB_UNUSED0 = 7'h2C;
  localparam logic [6:0] CODE_FB_UNUSED1 = 7'h2D;
  localparam logic [6:0] CODE_FB0_ACTIVE = 7'h2E;
  localparam logic [6:0] CODE_FB1_ACTIVE = 7'h2F;
  localparam logic [6:0] CODE_DL0_PHASE_LOCK = 7'h30;
  localparam logic [6:0] CODE_DL0_FREQ_LOCK = 7'h31;
  localparam logic [6:0] CODE_AL0_LOCK = 7'h32;
  localparam logic [6:0] CODE_AL0_CAL = 7'h33;
  localparam logic [6:0] CODE_DL0_ACTIVE = 7'h34;
  localparam logic [6:0] CODE_DL0_FREERUN = 7'h35;
  localparam logic [6:0] CODE_DL0_HOLDOVER = 7'h36;
  localparam logic [6:0] CODE_DL0_SWITCHING = 7'h37;
  localparam logic [6:0] CODE_DL0_TW_HIST = 7'h38;
  localparam logic [6:0] CODE_DL0_TW_UPDATED = 7'h39;
  localparam logic [6:0] CODE_DL0_FREQ_CLAMP = 7'h3A;
  localparam logic [6:0] CODE_DL0_SLEW_LIMIT = 7'h3B;
  // field positions inside the status bytes
  localparam int REF_FAULTED_BIT = 3;
  localparam int REF_VALID_BIT = 4;
  localparam int LOCK_PHASE_BIT = 1;
  localparam int LOCK_FREQ_BIT = 2;
  localparam int LOCK_ANALOG_BIT = 3;
  localparam int LOCK_CAL_BIT = 4;
  localparam int STATE_FREERUN_BIT = 0;
  localparam int STATE_HOLDOVER_BIT = 1;
  localparam int STATE_SWITCHING_BIT = 2;
  localparam int TW_HIST_BIT = 0;
  localparam int TW_CLAMP_BIT = 1;
  localparam int TW_SLEW_BIT = 2;
  localparam int EVENT_TW_UPDATED_BIT = 2;
  localparam int ACTIVE_SRC_MSB = 5;
  localparam int FAULT_CTRL_REF = 3;
  // reset values
  localparam logic PIN_RESET = 1'b0;
  localparam logic [3:0] VALIDATE_RESET = 4'h0;
endpackage

// ---- hdl/mfp_link_if.sv ----
// Purpose: carries decoded control and per-code status between the decoder parts
// Assumes: status index is code minus the first code of the range
// Notes: one driver per field, set by modport
`timescale 1ns/1ns
interface mfp_link_if;
  logic fault_lvl;
  logic [mfp_pkg::NUM_REFS-1:0] valid_rise;
  logic [mfp_pkg::STAT_W-1:0] status_vec;
  modport top (input fault_lvl, input valid_rise, output status_vec);
  modport indec (output fault_lvl, output valid_rise);
  modport outsel (input status_vec);
endinterface

// ---- hdl/mfp_in_decode.sv ----
// Purpose: synchronises input pins and turns their codes into control requests
// Assumes: pins are asynchronous to clock_i
// Notes: several pins on one code are ORed
`timescale 1ns/1ns
module mfp_in_decode #(
  parameter int NUM_PINS = 4
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic resetn_i,
  // pins
  input wire logic [NUM_PINS-1:0] pin_in_i,
  input wire logic [NUM_PINS-1:0] pin_dir_out_i,
  input wire logic [NUM_PINS*mfp_pkg::CODE_W-1:0] pin_code_i,
  // decoded requests
  mfp_link_if.indec link
);
  logic [NUM_PINS-1:0] meta_reg, meta_next;
  logic [NUM_PINS-1:0] sync_reg, sync_next;
  logic [NUM_PINS-1:0] prev_reg, prev_next;
  logic [NUM_PINS-1:0] is_fault;
  logic [NUM_PINS*mfp_pkg::NUM_REFS-1:0] is_rise;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    meta_next = pin_in_i;
    sync_next = meta_reg;
    prev_next = sync_reg;
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      meta_reg <= '0;
      sync_reg <= '0;
      prev_reg <= '0;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
      prev_reg <= prev_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // only matching codes on input pins count; every other code is dropped here
  for (genvar p = 0; p < NUM_PINS; p++) begin : g_pin
    logic [mfp_pkg::CODE_W-1:0] code;
    logic as_input;
    assign code = pin_code_i[p*mfp_pkg::CODE_W +: mfp_pkg::CODE_W]; // R1
    assign as_input = !pin_dir_out_i[p]; // R1
    assign is_fault[p] = as_input && (code == mfp_pkg::CODE_FAULT_REF3) && sync_reg[p]; // R2 R13
    for (genvar r = 0; r < mfp_pkg::NUM_REFS; r++) begin : g_ref
      // timeout validation acts once per rising edge, it is not a held level
      assign is_rise[p*mfp_pkg::NUM_REFS+r] = as_input && sync_reg[p] && !prev_reg[p]
        && (code == 7'(mfp_pkg::CODE_TIMEOUT_REF0 + r)); // R5 R13
    end
  end

  always_comb begin
    link.fault_lvl = |is_fault; // R2
    link.valid_rise = '0;
    for (int p = 0; p < NUM_PINS; p++) begin
      link.valid_rise = link.valid_rise | is_rise[p*mfp_pkg::NUM_REFS +: mfp_pkg::NUM_REFS]; // R5
    end
  end
endmodule

// ---- hdl/mfp_out_select.sv ----
// Purpose: picks the status source of each output pin from its code
// Assumes: status vector is already registered in the top
// Notes: codes outside the range drive low
`timescale 1ns/1ns
module mfp_out_select #(
  parameter int NUM_PINS = 4
) (
  // pin configuration
  input wire logic [NUM_PINS-1:0] pin_dir_out_i,
  input wire logic [NUM_PINS*mfp_pkg::CODE_W-1:0] pin_code_i,
  // status by code
  mfp_link_if.outsel link,
  // selected values
  output logic [NUM_PINS-1:0] pin_val_o,
  output logic [NUM_PINS-1:0] pin_oe_o
);
  for (genvar p = 0; p < NUM_PINS; p++) begin : g_pin
    logic [mfp_pkg::CODE_W-1:0] code;
    logic [mfp_pkg::CODE_W-1:0] idx;
    logic in_range;
    assign code = pin_code_i[p*mfp_pkg::CODE_W +: mfp_pkg::CODE_W]; // R1
    assign in_range = (code >= mfp_pkg::CODE_FIRST) && (code <= mfp_pkg::CODE_LAST);
    assign idx = 7'(code - mfp_pkg::CODE_FIRST);
    assign pin_val_o[p] = pin_dir_out_i[p] && in_range && link.status_vec[5'(idx)]; // R1
    assign pin_oe_o[p] = pin_dir_out_i[p]; // R1
  end
endmodule

// ---- hdl/mfp_pin_func.sv ----
// Purpose: top of the multifunction pin decoder for codes 0x23..0x3B
// Assumes: status bytes come from the status logic on clock_i
// Notes: all outputs registered; pin outputs come after the registered status vector, so a pin lags its status source by two cycles
`timescale 1ns/1ns
module mfp_pin_func #(
  parameter int NUM_PINS = 4
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic resetn_i,
  // multifunction pins
  input wire logic [NUM_PINS-1:0] pin_in_i,
  output logic [NUM_PINS-1:0] pin_out_o,
  output logic [NUM_PINS-1:0] pin_oe_o,
  // pin configuration
  input wire logic [NUM_PINS-1:0] pin_dir_out_i,
  input wire logic [NUM_PINS*mfp_pkg::CODE_W-1:0] pin_code_i,
  // reference status, one byte per ref_in_0..ref_in_3
  input wire logic [7:0] ref_in_0_status_i,
  input wire logic [7:0] ref_in_1_status_i,
  input wire logic [7:0] ref_in_2_status_i,
  input wire logic [7:0] ref_in_3_status_i,
  // reference selection of digital_loop_0
  input wire logic [1:0] active_ref_sel_i,
  // digital_loop_0 and analog_loop_0 status bytes
  input wire logic [7:0] loop_lock_status_i,
  input wire logic [7:0] loop_state_status_i,
  input wire logic [7:0] tuning_status_i,
  input wire logic [7:0] active_src_status_i,
  input wire logic [7:0] loop_event_status_i,
  // feedback paths
  input wire logic [1:0] feedback_active_i,
  // software control bit merged with the pin proxy
  input wire logic fault_ref_in_3_sw_i,
  // control results
  output logic fault_ref_in_3_o,
  output logic [mfp_pkg::NUM_REFS-1:0] validate_ref_o
);
  mfp_link_if link ();

  logic [7:0] ref_status [mfp_pkg::NUM_REFS];
  logic [mfp_pkg::NUM_REFS-1:0] ref_faulted;
  logic [mfp_pkg::NUM_REFS-1:0] ref_valid;
  logic [mfp_pkg::NUM_REFS-1:0] ref_active;
  logic dl0_active;
  logic dl0_tracking;
  logic [mfp_pkg::STAT_W-1:0] stat_reg, stat_next;
  logic [NUM_PINS-1:0] pin_val;
  logic [NUM_PINS-1:0] pin_en;
  logic [NUM_PINS-1:0] out_reg, out_next;
  logic [NUM_PINS-1:0] oe_reg, oe_next;
  logic fault_reg, fault_next;
  logic [mfp_pkg::NUM_REFS-1:0] valid_reg, valid_next;

  assign ref_status[0] = ref_in_0_status_i;
  assign ref_status[1] = ref_in_1_status_i;
  assign ref_status[2] = ref_in_2_status_i;
  assign ref_status[3] = ref_in_3_status_i;

  ////////////////////////////////////////////////////////////////////////////
  // input side
  mfp_in_decode #(
    .NUM_PINS(NUM_PINS)
  ) u_in_decode (
    .clock_i(clock_i),
    .resetn_i(resetn_i),
    .pin_in_i(pin_in_i),
    .pin_dir_out_i(pin_dir_out_i),
    .pin_code_i(pin_code_i),
    .link(link)
  );

  ////////////////////////////////////////////////////////////////////////////
  // derived status
  assign dl0_active = |active_src_status_i[mfp_pkg::ACTIVE_SRC_MSB:0]; // R9
  // freerun and holdover mean no reference is steering the loop
  assign dl0_tracking = dl0_active && !loop_state_status_i[mfp_pkg::STATE_FREERUN_BIT]
    && !loop_state_status_i[mfp_pkg::STATE_HOLDOVER_BIT]; // R6

  for (genvar r = 0; r < mfp_pkg::NUM_REFS; r++) begin : g_ref
    assign ref_faulted[r] = ref_status[r][mfp_pkg::REF_FAULTED_BIT]; // R3
    assign ref_valid[r] = ref_status[r][mfp_pkg::REF_VALID_BIT]; // R4
    // active: valid, not faulted, selected, and the loop is tracking it
    assign ref_active[r] = ref_valid[r] && !ref_faulted[r] && dl0_tracking
      && (active_ref_sel_i == 2'(r)); // R6
  end

  // index of a code in the status vector
  function automatic int sidx(input logic [6:0] code);
    sidx = int'(code) - int'(mfp_pkg::CODE_FIRST);
  endfunction

  always_comb begin
    stat_next = '0;
    stat_next[sidx(mfp_pkg::CODE_FAULT_REF3)] = ref_faulted[mfp_pkg::FAULT_CTRL_REF]; // R3
    for (int r = 0; r < mfp_pkg::NUM_REFS; r++) begin
      stat_next[sidx(mfp_pkg::CODE_VALID_REF0) + r] = ref_valid[r]; // R4
      stat_next[sidx(mfp_pkg::CODE_ACTIVE_REF0) + r] = ref_active[r]; // R6
    end
    stat_next[sidx(mfp_pkg::CODE_FB_UNUSED0)] = 1'b0; // R14
    stat_next[sidx(mfp_pkg::CODE_FB_UNUSED1)] = 1'b0; // R14
    stat_next[sidx(mfp_pkg::CODE_FB0_ACTIVE)] = feedback_active_i[0]; // R14
    stat_next[sidx(mfp_pkg::CODE_FB1_ACTIVE)] = feedback_active_i[1]; // R14
    stat_next[sidx(mfp_pkg::CODE_DL0_PHASE_LOCK)] = loop_lock_status_i[mfp_pkg::LOCK_PHASE_BIT]; // R7
    stat_next[sidx(mfp_pkg::CODE_DL0_FREQ_LOCK)] = loop_lock_status_i[mfp_pkg::LOCK_FREQ_BIT]; // R7
    stat_next[sidx(mfp_pkg::CODE_AL0_LOCK)] = loop_lock_status_i[mfp_pkg::LOCK_ANALOG_BIT]; // R7
    stat_next[sidx(mfp_pkg::CODE_AL0_CAL)] = loop_lock_status_i[mfp_pkg::LOCK_CAL_BIT]; // R8
    stat_next[sidx(mfp_pkg::CODE_DL0_ACTIVE)] = dl0_active; // R9
    stat_next[sidx(mfp_pkg::CODE_DL0_FREERUN)] = loop_state_status_i[mfp_pkg::STATE_FREERUN_BIT]; // R10
    stat_next[sidx(mfp_pkg::CODE_DL0_HOLDOVER)] = loop_state_status_i[mfp_pkg::STATE_HOLDOVER_BIT]; // R10
    stat_next[sidx(mfp_pkg::CODE_DL0_SWITCHING)] = loop_state_status_i[mfp_pkg::STATE_SWITCHING_BIT]; // R10
    stat_next[sidx(mfp_pkg::CODE_DL0_TW_HIST)] = tuning_status_i[mfp_pkg::TW_HIST_BIT]; // R11
    stat_next[sidx(mfp_pkg::CODE_DL0_FREQ_CLAMP)] = tuning_status_i[mfp_pkg::TW_CLAMP_BIT]; // R11
    stat_next[sidx(mfp_pkg::CODE_DL0_SLEW_LIMIT)] = tuning_status_i[mfp_pkg::TW_SLEW_BIT]; // R11
    stat_next[sidx(mfp_pkg::CODE_DL0_TW_UPDATED)] = loop_event_status_i[mfp_pkg::EVENT_TW_UPDATED_BIT]; // R12
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      stat_reg <= '0;
    end else begin
      stat_reg <= stat_next;
    end
  end

  assign link.status_vec = stat_reg;

  ////////////////////////////////////////////////////////////////////////////
  // output side
  mfp_out_select #(
    .NUM_PINS(NUM_PINS)
  ) u_out_select (
    .pin_dir_out_i(pin_dir_out_i),
    .pin_code_i(pin_code_i),
    .link(link),
    .pin_val_o(pin_val),
    .pin_oe_o(pin_en)
  );

  ////////////////////////////////////////////////////////////////////////////
  // registered results
  always_comb begin
    out_next = pin_val;
    oe_next = pin_en;
    fault_next = fault_ref_in_3_sw_i || link.fault_lvl; // R2
    // a validation request on a healthy reference is simply dropped
    valid_next = link.valid_rise & ref_faulted; // R5
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      out_reg <= '0;
      oe_reg <= '0;
      fault_reg <= mfp_pkg::PIN_RESET;
      valid_reg <= mfp_pkg::VALIDATE_RESET;
    end else begin
      out_reg <= out_next;
      oe_reg <= oe_next;
      fault_reg <= fault_next;
      valid_reg <= valid_next;
    end
  end

  assign pin_out_o = out_reg;
  assign pin_oe_o = oe_reg;
  assign fault_ref_in_3_o = fault_reg;
  assign validate_ref_o = valid_reg;
endmodule

// ---- tb/mfp_exp.svh ----
// Purpose: expected level of an output pin for one function code
// Assumes: s = {fb, sel, event, active src, tuning, state, lock, ref3..ref0}
// Notes: kept apart from the design so a shared slip cannot hide
`ifndef MFP_EXP_SVH
`define MFP_EXP_SVH
function automatic logic mfp_expect(input logic [6:0] c, input logic [75:0] s);
  case (c)
    7'h23: return s[27];
    7'h24, 7'h25, 7'h26, 7'h27: return s[{c[1:0], 3'd4}];
    7'h28, 7'h29, 7'h2A, 7'h2B: return s[{c[1:0], 3'd4}] & !s[{c[1:0], 3'd3}] & (s[73:72] == c[1:0])
      & (|s[61:56]) & !s[40] & !s[41];
    7'h2E, 7'h2F: return s[72 + c[1:0]];
    7'h30, 7'h31, 7'h32, 7'h33: return s[33 + c[1:0]];
    7'h34: return |s[61:56];
    7'h35, 7'h36, 7'h37: return s[39 + c[1:0]];
    7'h38: return s[48];
    7'h39: return s[66];
    7'h3A, 7'h3B: return s[47 + c[1:0]];
    default: return 1'b0;
  endcase
endfunction
`endif

// ---- tb/mfp_board.sv ----
// Purpose: board logic standing on the multifunction pins
// Assumes: lvl_i is what the board wants on pins the device does not drive
// Notes: pins driven by the device read back as a flipping pattern
`timescale 1ns/1ns
module mfp_board #(parameter int NUM_PINS = 4) (
  // clock
  input wire logic clock_i,
  // direction and requested levels
  input wire logic [NUM_PINS-1:0] dir_i,
  input wire logic [NUM_PINS-1:0] lvl_i,
  // pin levels into the device
  output logic [NUM_PINS-1:0] pin_o
);
  logic tog = 1'b0;
  always @(posedge clock_i) tog <= ~tog;
  // a stale level must never pass for a real drive
  assign pin_o = (lvl_i & ~dir_i) | ({NUM_PINS{tog}} & dir_i);
endmodule

// ---- tb/mfp_pin_func_assertions.sv ----
// Purpose: port-level checks of the pin function decoder
// Assumes: pin 0 is the pin under test, other pins are outputs when pin 0 is an input
// Notes: expected status levels come from mfp_expect
`timescale 1ns/1ns
`include "mfp_exp.svh"
module mfp_pin_func_chk #(parameter int NUM_PINS = 4) (
  // clock and reset
  input wire logic clock_i,
  input wire logic resetn_i,
  // pins and configuration
  input wire logic [NUM_PINS-1:0] pin_in_i,
  input wire logic [NUM_PINS-1:0] pin_out_o,
  input wire logic [NUM_PINS-1:0] pin_oe_o,
  input wire logic [NUM_PINS-1:0] pin_dir_out_i,
  input wire logic [NUM_PINS*mfp_pkg::CODE_W-1:0] pin_code_i,
  // status sources
  input wire logic [7:0] ref_in_0_status_i,
  input wire logic [7:0] ref_in_1_status_i,
  input wire logic [7:0] ref_in_2_status_i,
  input wire logic [7:0] ref_in_3_status_i,
  input wire logic [1:0] active_ref_sel_i,
  input wire logic [7:0] loop_lock_status_i,
  input wire logic [7:0] loop_state_status_i,
  input wire logic [7:0] tuning_status_i,
  input wire logic [7:0] active_src_status_i,
  input wire logic [7:0] loop_event_status_i,
  input wire logic [1:0] feedback_active_i,
  // control
  input wire logic fault_ref_in_3_sw_i,
  input wire logic fault_ref_in_3_o,
  input wire logic [mfp_pkg::NUM_REFS-1:0] validate_ref_o
);
  logic [1:0] rdy;
  logic [2:0] hc;
  logic [NUM_PINS*8-1:0] cfg_q;
  logic [75:0] st_q;
  logic [6:0] code_q;
  logic want;
  logic want_q;
  logic inp;
  assign want = mfp_expect(pin_code_i[6:0], st_q);
  // input checks only once the configuration has settled past the synchroniser
  assign inp = hc == 3'h7 && {pin_code_i, pin_dir_out_i} == cfg_q && pin_dir_out_i == {{(NUM_PINS-1){1'b1}}, 1'b0};
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdy <= 2'h0;
      hc <= 3'h0;
      cfg_q <= '0;
      st_q <= '0;
      code_q <= 7'h00;
      want_q <= 1'b0;
    end else begin
      rdy <= rdy + {1'b0, rdy != 2'h3};
      hc <= ({pin_code_i, pin_dir_out_i} != cfg_q) ? 3'h0 : hc + {2'h0, hc != 3'h7};
      cfg_q <= {pin_code_i, pin_dir_out_i};
      st_q <= {feedback_active_i, active_ref_sel_i, loop_event_status_i, active_src_status_i, tuning_status_i,
        loop_state_status_i, loop_lock_status_i, ref_in_3_status_i, ref_in_2_status_i, ref_in_1_status_i,
        ref_in_0_status_i};
      code_q <= pin_code_i[6:0];
      want_q <= want;
    end
  end
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!resetn_i);
  ////////////////////////////////////////////////////////////////////////////
  property p_oe; rdy == 2'h3 |-> pin_oe_o == $past(pin_dir_out_i); endproperty
  a_oe: assert property (p_oe) else $error("oe lag");
  property p_ref; rdy == 2'h3 && pin_oe_o[0] && code_q inside {[7'h23:7'h27]} |-> pin_out_o[0] == want_q; endproperty
  a_ref: assert property (p_ref) else $error("ref flag");
  property p_act; rdy == 2'h3 && pin_oe_o[0] && code_q inside {[7'h28:7'h2F]} |-> pin_out_o[0] == want_q; endproperty
  a_act: assert property (p_act) else $error("active flag");
  property p_loop; rdy == 2'h3 && pin_oe_o[0] && code_q inside {[7'h30:7'h3B]} |-> pin_out_o[0] == want_q; endproperty
  a_loop: assert property (p_loop) else $error("loop flag");
  property p_fault; inp && pin_code_i[6:0] == 7'h23
    |-> fault_ref_in_3_o == ($past(fault_ref_in_3_sw_i) | $past(pin_in_i[0], 3)); endproperty
  a_fault: assert property (p_fault) else $error("fault proxy");
  property p_nofault; inp && pin_code_i[6:0] != 7'h23 |-> fault_ref_in_3_o == $past(fault_ref_in_3_sw_i); endproperty
  a_nofault: assert property (p_nofault) else $error("stray fault");
  // the faulted flag is taken at the same edge as the synchronised rise
  property p_vfire; inp && pin_code_i[6:0] == 7'h28 && $past(pin_in_i[0], 3) && !$past(pin_in_i[0], 4)
    && $past(ref_in_0_status_i[3]) |-> validate_ref_o[0]; endproperty
  a_vfire: assert property (p_vfire) else $error("no validate");
  property p_vnone; inp && !(pin_code_i[6:0] inside {[7'h28:7'h2B]}) |-> validate_ref_o == 4'h0; endproperty
  a_vnone: assert property (p_vnone) else $error("stray validate");
  property p_vone; validate_ref_o[0] |=> !validate_ref_o[0]; endproperty
  a_vone: assert property (p_vone) else $error("long validate");
endmodule
bind mfp_pin_func mfp_pin_func_chk #(.NUM_PINS(NUM_PINS)) u_chk (.clock_i, .resetn_i, .pin_in_i, .pin_out_o,
  .pin_oe_o, .pin_dir_out_i, .pin_code_i, .ref_in_0_status_i, .ref_in_1_status_i, .ref_in_2_status_i,
  .ref_in_3_status_i, .active_ref_sel_i, .loop_lock_status_i, .loop_state_status_i, .tuning_status_i,
  .active_src_status_i, .loop_event_status_i, .feedback_active_i, .fault_ref_in_3_sw_i, .fault_ref_in_3_o,
  .validate_ref_o);

// ---- tb/test_mfp_pin_func.sv ----
// Purpose: scoreboard bench for the pin function decoder
// Assumes: four pins, pin 0 under test
// Notes: notes carry the cycle at which each result must show
`timescale 1ns/1ns
`include "mfp_exp.svh"
module test_mfp_pin_func;
  typedef struct {int cyc; int sel; logic [7:0] val;} mfp_note_s;
  logic clock_i = 1'b0;
  logic resetn_i = 1'b0;
  logic [3:0] pin_in_i, pin_out_o, pin_oe_o, validate_ref_o;
  logic [3:0] pin_dir_out_i = 4'hf;
  logic [3:0] lvl = 4'h0;
  logic [27:0] pin_code_i = '0;
  logic [75:0] s = '0;
  logic sw = 1'b0;
  logic fault_ref_in_3_o;
  int errors = 0;
  int checks_done = 0;
  int cyc = 0;
  mfp_note_s q[$];
  always #50 clock_i = ~clock_i;
  mfp_board u_board (.clock_i, .dir_i(pin_dir_out_i), .lvl_i(lvl), .pin_o(pin_in_i));
  mfp_pin_func u_dut (.clock_i, .resetn_i, .pin_in_i, .pin_out_o, .pin_oe_o, .pin_dir_out_i, .pin_code_i,
    .ref_in_0_status_i(s[7:0]), .ref_in_1_status_i(s[15:8]), .ref_in_2_status_i(s[23:16]),
    .ref_in_3_status_i(s[31:24]), .active_ref_sel_i(s[73:72]), .loop_lock_status_i(s[39:32]),
    .loop_state_status_i(s[47:40]), .tuning_status_i(s[55:48]), .active_src_status_i(s[63:56]),
    .loop_event_status_i(s[71:64]), .feedback_active_i(s[75:74]), .fault_ref_in_3_sw_i(sw),
    .fault_ref_in_3_o, .validate_ref_o);
  ////////////////////////////////////////////////////////////////////////////
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    checks_done++;
    if (seen !== want) begin
      errors++;
      $display("ERROR t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask
  task automatic note(input int dly, input int sel, input logic [7:0] val);
    q.push_back('{cyc + dly, sel, val});
  endtask
  // a hang is cut short well past the longest expected run
  always @(posedge clock_i) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      errors++;
      final_report();
    end
  end
  always @(negedge clock_i) begin
    while (q.size() != 0 && q[0].cyc <= cyc) begin
      case (q[0].sel)
        0: check({4'h0, pin_out_o}, q[0].val);
        1: check({7'h00, fault_ref_in_3_o}, q[0].val);
        2: check({4'h0, validate_ref_o}, q[0].val);
        default: check({4'h0, pin_oe_o}, q[0].val);
      endcase
      q.delete(0);
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic out_code(input logic [6:0] c, input bit bias);
    logic [95:0] t;
    logic [75:0] v;
    logic [27:0] k;
    logic [3:0] e;
    t = {$urandom(), $urandom(), $urandom()};
    v = t[75:0];
    // bias so the reference active combination is seen true
    if (bias) v = (v & ~76'h300_0808_0808) | 76'h0100_0000_1010_1010;
    if (bias) v[73:72] = c[1:0];
    k = {t[95:76], t[0], c};
    // every pin carries its own code, so each output bit has its own expectation
    for (int p = 0; p < 4; p++) e[p] = mfp_expect(k[p*7 +: 7], v);
    @(posedge clock_i);
    s <= v;
    pin_dir_out_i <= 4'hf;
    pin_code_i <= k;
    note(3, 0, {4'h0, e});
    note(3, 3, 8'h0f);
    repeat (2) @(posedge clock_i);
  endtask
  task automatic in_code(input logic [6:0] c, input bit all_flt);
    logic [3:0] f;
    logic [75:0] v;
    // one pass with every reference faulted so each validate code must pulse
    f = all_flt ? 4'hf : 4'($urandom());
    v = s;
    {v[27], v[19], v[11], v[3]} = f;
    @(posedge clock_i);
    s <= v;
    pin_dir_out_i <= 4'he;
    pin_code_i[6:0] <= c;
    repeat (8) @(posedge clock_i);
    lvl <= 4'h1;
    note(4, 1, {7'h00, c == 7'h23});
    note(4, 3, 8'h0e);
    note(4, 2, (c inside {[7'h28:7'h2B]}) ? {4'h0, f & (4'h1 << c[1:0])} : 8'h00);
    note(5, 2, 8'h00);
    repeat (4) @(posedge clock_i);
    lvl <= 4'h0;
    sw <= 1'b1;
    note(2, 1, 8'h01);
    @(posedge clock_i);
    sw <= 1'b0;
    note(2, 1, {7'h00, c == 7'h23});
    repeat (4) @(posedge clock_i);
  endtask
  initial begin
    void'($urandom(32'h9f30_e21c));
    repeat (8) @(posedge clock_i);
    resetn_i <= 1'b1;
    for (int r = 0; r < 3; r++) begin
      for (int c = 'h22; c <= 'h3c; c++) out_code(c[6:0], r == 0);
    end
    $display("test status outputs done");
    for (int m = 0; m < 2; m++) begin
      for (int c = 'h22; c <= 'h3c; c++) in_code(c[6:0], m == 0);
    end
    $display("test control inputs done");
    repeat (8) @(posedge clock_i);
    final_report();
  end
endmodule
